// file: fci_pkg.sv
package fci_pkg;

    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_ID    = 8'h90;
    localparam logic [7:0] CMD_QUERY      = 8'h98;
    localparam logic [7:0] CMD_STATUS     = 8'h70;
    localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
    localparam logic [7:0] CMD_BUFFER     = 8'he8;
    localparam logic [7:0] CMD_PROGRAM    = 8'h40;
    localparam logic [7:0] CMD_ERASE      = 8'h20;
    localparam logic [7:0] CMD_SUSPEND    = 8'hb0;
    localparam logic [7:0] CMD_CONFIRM    = 8'hd0;
    localparam logic [7:0] CMD_CONFIG     = 8'hb8;
    localparam logic [7:0] CMD_LOCK       = 8'h60;
    localparam logic [7:0] CMD_LOCK_SET   = 8'h01;
    localparam logic [7:0] CMD_RCFG_CONF  = 8'h03;
    localparam logic [7:0] CMD_PROTECT    = 8'hc0;

    // ****************************************************************
    // Field positions and limits
    // ****************************************************************
    localparam int         SR_READY_BIT   = 7;
    localparam logic [4:0] BUF_MAX_BYTE   = 5'h1f;
    localparam logic [4:0] BUF_MAX_WORD   = 5'h0f;
    localparam logic [7:0] UPPER_FILL     = 8'h00;
    localparam int         ADDR_W         = 24;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PS     = 4000;
    localparam int T_WP_NS    = 70;
    localparam int T_WPH_NS   = 30;
    localparam int T_RD_NS    = 150;
    localparam int WP_CYC     = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WPH_CYC    = (T_WPH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RD_CYC     = (T_RD_NS * 1000 + CLK_PS - 1) / CLK_PS;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        OP_READ_ARRAY, OP_READ_ID, OP_QUERY, OP_STATUS, OP_CLR_STATUS,
        OP_PROGRAM, OP_BUFFER, OP_ERASE, OP_SUSPEND, OP_RESUME,
        OP_CONFIG, OP_LOCK_SET, OP_LOCK_CLEAR, OP_PROTECT, OP_RCFG
    } fci_op_e;

    typedef enum logic [2:0] {
        K_DONE, K_WCODE, K_WUSER, K_WCOUNT, K_WBUF, K_READ, K_POLL, K_WRCFG
    } fci_kind_e;

    typedef struct packed {
        fci_kind_e  kind;
        logic [7:0] code;
    } fci_step_s;

    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              byte_n;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       dq_out;
        logic              dq_oe;
    } fci_pins_s;

    typedef struct packed {
        fci_op_e           op;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       data;
    } fci_req_s;

endpackage

// file: fci_host.sv
`timescale 1ns/1ns
// Functional notes
// - Host issues only the defined command codes, nothing reserved.
// - Read configuration payload goes on address lines 16 to 1.
// - After buffer command, host polls availability until a buffer is free.
// - Host sends count N then N+1 entries; N limited by bus mode.
// - In x8 mode the host drives the lowest address line; query reads and read configuration writes hold it low.
module fci_host #(
    parameter int WP_CYCLES  = fci_pkg::WP_CYC,
    parameter int WPH_CYCLES = fci_pkg::WPH_CYC,
    parameter int RD_CYCLES  = fci_pkg::RD_CYC
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             req_valid,
    input  wire fci_pkg::fci_req_s req,
    output logic                  req_ready,
    input  wire logic             byte_mode,
    input  wire logic             prog_enable,
    input  wire logic             buf_valid,
    input  wire logic [15:0]      buf_data,
    output logic                  buf_ready,
    output logic                  rsp_valid,
    output logic                  rsp_err,
    output logic [15:0]           rsp_data,
    output fci_pkg::fci_pins_s    pins,
    output logic                  program_enable_supply_drive,
    input  wire logic [15:0]      dq_in
);

    if (WP_CYCLES < 1 || WP_CYCLES > 255 || WPH_CYCLES < 1 || WPH_CYCLES > 255 ||
        RD_CYCLES < 1 || RD_CYCLES > 255) begin : g_bad_cycles
        $error("fci_host: cycle counts must be 1 to 255");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [2:0] {ST_IDLE, ST_NEXT, ST_WE, ST_HOLD, ST_RD} fci_st_e;

    typedef struct packed {
        fci_st_e                   st;
        fci_pkg::fci_op_e          op;
        logic [2:0]                step;
        logic [7:0]                cnt;
        logic [fci_pkg::ADDR_W-1:0] addr;
        logic [15:0]               data;
        logic [4:0]                words;
        fci_pkg::fci_pins_s        pins;
        logic                      req_ready;
        logic                      buf_ready;
        logic                      rsp_valid;
        logic                      rsp_err;
        logic [15:0]               rsp_data;
        logic                      program_enable_supply;
    } fci_state_s;

    fci_state_s r;
    fci_state_s next_r;

    localparam logic [7:0] WP_LAST  = 8'(WP_CYCLES - 1);
    localparam logic [7:0] WPH_LAST = 8'(WPH_CYCLES - 1);
    localparam logic [7:0] RD_LAST  = 8'(RD_CYCLES - 1);

    // ****************************************************************
    // Command sequences
    // ****************************************************************
    function automatic fci_pkg::fci_step_s plan(fci_pkg::fci_op_e op, logic [2:0] step);
        fci_pkg::fci_step_s s;
        s = '{kind: fci_pkg::K_DONE, code: fci_pkg::CMD_READ_ARRAY};
        case (op)
            fci_pkg::OP_READ_ARRAY: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_READ_ARRAY};
            end
            fci_pkg::OP_READ_ID: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_READ_ID};
                if (step == 3'h1) s = '{fci_pkg::K_READ, fci_pkg::CMD_READ_ID};
            end
            fci_pkg::OP_QUERY: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_QUERY};
                if (step == 3'h1 || step == 3'h2) s = '{fci_pkg::K_READ, fci_pkg::CMD_QUERY};
            end
            fci_pkg::OP_STATUS: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_STATUS};
                if (step == 3'h1) s = '{fci_pkg::K_READ, fci_pkg::CMD_STATUS};
            end
            fci_pkg::OP_CLR_STATUS: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_CLR_STATUS};
            end
            fci_pkg::OP_PROGRAM: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_PROGRAM};
                if (step == 3'h1) s = '{fci_pkg::K_WUSER, fci_pkg::CMD_PROGRAM};
            end
            fci_pkg::OP_BUFFER: begin
                case (step)
                    3'h0:    s = '{fci_pkg::K_WCODE, fci_pkg::CMD_BUFFER};
                    3'h1:    s = '{fci_pkg::K_POLL, fci_pkg::CMD_BUFFER};
                    3'h2:    s = '{fci_pkg::K_WCOUNT, fci_pkg::CMD_BUFFER};
                    3'h3:    s = '{fci_pkg::K_WBUF, fci_pkg::CMD_BUFFER};
                    3'h4:    s = '{fci_pkg::K_WCODE, fci_pkg::CMD_CONFIRM};
                    default: s = '{fci_pkg::K_DONE, fci_pkg::CMD_BUFFER};
                endcase
            end
            fci_pkg::OP_ERASE: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_ERASE};
                if (step == 3'h1) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_CONFIRM};
            end
            fci_pkg::OP_SUSPEND: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_SUSPEND};
            end
            fci_pkg::OP_RESUME: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_CONFIRM};
            end
            fci_pkg::OP_CONFIG: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_CONFIG};
                if (step == 3'h1) s = '{fci_pkg::K_WUSER, fci_pkg::CMD_CONFIG};
            end
            fci_pkg::OP_LOCK_SET: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_LOCK};
                if (step == 3'h1) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_LOCK_SET};
            end
            fci_pkg::OP_LOCK_CLEAR: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_LOCK};
                if (step == 3'h1) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_CONFIRM};
            end
            fci_pkg::OP_PROTECT: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_PROTECT};
                if (step == 3'h1) s = '{fci_pkg::K_WUSER, fci_pkg::CMD_PROTECT};
            end
            fci_pkg::OP_RCFG: begin
                if (step == 3'h0) s = '{fci_pkg::K_WCODE, fci_pkg::CMD_LOCK};
                if (step == 3'h1) s = '{fci_pkg::K_WRCFG, fci_pkg::CMD_RCFG_CONF};
            end
            default: s = '{fci_pkg::K_DONE, fci_pkg::CMD_READ_ARRAY};
        endcase
        return s;
    endfunction

    function automatic logic alters(fci_pkg::fci_op_e op);
        return op == fci_pkg::OP_PROGRAM || op == fci_pkg::OP_BUFFER ||
               op == fci_pkg::OP_ERASE || op == fci_pkg::OP_LOCK_SET ||
               op == fci_pkg::OP_LOCK_CLEAR || op == fci_pkg::OP_PROTECT ||
               op == fci_pkg::OP_CONFIG || op == fci_pkg::OP_RCFG;
    endfunction

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        fci_pkg::fci_step_s s;
        logic [4:0]         max_n;
        logic [fci_pkg::ADDR_W-1:0] qa;
        s      = plan(r.op, r.step);
        max_n  = byte_mode ? fci_pkg::BUF_MAX_BYTE : fci_pkg::BUF_MAX_WORD;
        qa     = r.addr + fci_pkg::ADDR_W'(r.step == 3'h2);
        next_r = r;
        next_r.rsp_valid   = 1'b0;
        next_r.pins.byte_n = ~byte_mode;
        case (r.st)
            ST_IDLE: begin
                if (req_valid && r.req_ready) begin
                    next_r.req_ready = 1'b0;
                    if ((alters(req.op) && !prog_enable) ||
                        (req.op == fci_pkg::OP_BUFFER && req.data[4:0] > max_n) ||
                        (req.op == fci_pkg::OP_BUFFER && req.data[15:5] != 11'h000)) begin
                        next_r.rsp_valid = 1'b1;
                        next_r.rsp_err   = 1'b1;
                        next_r.req_ready = 1'b1;
                    end else begin
                        next_r.op      = req.op;
                        next_r.addr    = req.addr;
                        next_r.data    = req.data;
                        next_r.words   = req.data[4:0];
                        next_r.step    = 3'h0;
                        next_r.rsp_err = 1'b0;
                        next_r.program_enable_supply    = alters(req.op);
                        next_r.st      = ST_NEXT;
                    end
                end
            end
            ST_NEXT: begin
                // Word mode shifts the unit address up; byte mode drives A0 itself
                next_r.pins.addr = byte_mode ? r.addr : {r.addr[fci_pkg::ADDR_W-2:0], 1'b0};
                next_r.pins.dq_out = {fci_pkg::UPPER_FILL, s.code};
                case (s.kind)
                    fci_pkg::K_DONE: begin
                        next_r.st        = ST_IDLE;
                        next_r.rsp_valid = 1'b1;
                        next_r.req_ready = 1'b1;
                        next_r.program_enable_supply      = 1'b0;
                    end
                    fci_pkg::K_READ, fci_pkg::K_POLL: begin
                        if (r.op == fci_pkg::OP_QUERY) begin
                            next_r.pins.addr = {qa[fci_pkg::ADDR_W-2:0], 1'b0};
                        end
                        next_r.pins.ce_n = 1'b0;
                        next_r.pins.oe_n = 1'b0;
                        next_r.cnt       = RD_LAST;
                        next_r.st        = ST_RD;
                    end
                    fci_pkg::K_WBUF: begin
                        next_r.buf_ready = 1'b1;
                        if (buf_valid && r.buf_ready) begin
                            next_r.buf_ready   = 1'b0;
                            next_r.pins.dq_out = buf_data;
                            next_r.pins.dq_oe  = 1'b1;
                            next_r.pins.ce_n   = 1'b0;
                            next_r.pins.we_n   = 1'b0;
                            next_r.cnt         = WP_LAST;
                            next_r.st          = ST_WE;
                        end
                    end
                    default: begin
                        if (s.kind == fci_pkg::K_WUSER) next_r.pins.dq_out = r.data;
                        if (s.kind == fci_pkg::K_WCOUNT) begin
                            next_r.pins.dq_out = {11'h000, r.words};
                        end
                        if (s.kind == fci_pkg::K_WRCFG) begin
                            next_r.pins.addr = {7'h00, r.data, 1'b0};
                        end
                        next_r.pins.dq_oe = 1'b1;
                        next_r.pins.ce_n  = 1'b0;
                        next_r.pins.we_n  = 1'b0;
                        next_r.cnt        = WP_LAST;
                        next_r.st         = ST_WE;
                    end
                endcase
            end
            ST_WE: begin
                next_r.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00) begin
                    next_r.pins.we_n = 1'b1; // Payload still driven past this edge
                    next_r.cnt       = WPH_LAST;
                    next_r.st        = ST_HOLD;
                end
            end
            ST_HOLD: begin
                next_r.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00) begin
                    next_r.pins.ce_n  = 1'b1;
                    next_r.pins.dq_oe = 1'b0;
                    next_r.st         = ST_NEXT;
                    if (s.kind == fci_pkg::K_WBUF && r.words != 5'h00) begin
                        next_r.words = r.words - 5'h01;
                    end else begin
                        next_r.step = r.step + 3'h1;
                    end
                end
            end
            ST_RD: begin
                next_r.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00) begin
                    next_r.pins.ce_n = 1'b1;
                    next_r.pins.oe_n = 1'b1;
                    next_r.st        = ST_NEXT;
                    next_r.step      = r.step + 3'h1;
                    if (s.kind == fci_pkg::K_POLL) begin
                        if (!dq_in[fci_pkg::SR_READY_BIT]) next_r.step = 3'h0;
                    end else if (r.op == fci_pkg::OP_QUERY) begin
                        if (r.step == 3'h1) begin
                            next_r.rsp_data = {fci_pkg::UPPER_FILL, dq_in[7:0]};
                        end else begin
                            next_r.rsp_data[15:8] = dq_in[7:0];
                        end
                    end else if (r.op == fci_pkg::OP_STATUS && !dq_in[fci_pkg::SR_READY_BIT]) begin
                        next_r.rsp_data = 16'h0000;
                    end else begin
                        next_r.rsp_data = dq_in;
                    end
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
    end

    // Reset idles the host with op at OP_READ_ARRAY and all strobes high; no command is sent to the device
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r           <= '0;
            r.st        <= ST_IDLE;
            r.op        <= fci_pkg::OP_READ_ARRAY;
            r.pins.ce_n <= 1'b1;
            r.pins.oe_n <= 1'b1;
            r.pins.we_n <= 1'b1;
            r.pins.byte_n <= 1'b1;
            r.req_ready <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign req_ready  = r.req_ready;
    assign buf_ready  = r.buf_ready;
    assign rsp_valid  = r.rsp_valid;
    assign rsp_err    = r.rsp_err;
    assign rsp_data   = r.rsp_data;
    assign pins       = r.pins;
    assign program_enable_supply_drive = r.program_enable_supply;

endmodule // fci_host

// file: fci_host_props.sv
`timescale 1ns/1ns
module fci_host_props #(
    parameter int WP_CYCLES = 1
) (
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input wire logic               req_valid,
    input wire fci_pkg::fci_req_s  req,
    input wire logic               req_ready,
    input wire logic               byte_mode,
    input wire logic               prog_enable,
    input wire logic               rsp_valid,
    input wire logic               rsp_err,
    input wire fci_pkg::fci_pins_s pins,
    input wire logic               program_enable_supply_drive
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] lo_cnt;
    // ****************************************
    // Strobe width counter
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
            lo_cnt <= 8'h00;
        else
            lo_cnt <= pins.we_n ? 8'h00 : lo_cnt + 8'h01;
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_refused;
        rsp_valid && rsp_err;
    endsequence
    a_refuse_supply: assert property (s_take ##0 (req.op == fci_pkg::OP_PROGRAM && !prog_enable)
        |-> ##[1:2] s_refused) else $error("program not refused without supply");
    a_refuse_count: assert property (s_take ##0 (req.op == fci_pkg::OP_BUFFER
        && req.data > (byte_mode ? 16'h001f : 16'h000f)) |-> ##[1:2] s_refused)
        else $error("buffer count over limit not refused");
    a_program_enable_supply_idle: assert property (s_take ##0 !prog_enable |=> !program_enable_supply_drive [*2])
        else $error("supply driven while disabled");
    a_strobe_width: assert property ($rose(pins.we_n) |-> lo_cnt == WP_CYCLES)
        else $error("write strobe width wrong");
    a_write_sel: assert property (!pins.we_n |-> !pins.ce_n && pins.dq_oe && pins.oe_n)
        else $error("write strobe without select or data");
    a_no_fight: assert property (!(!pins.oe_n && pins.dq_oe))
        else $error("host drives data during read");
    a_byte_pin: assert property ($stable(byte_mode) |-> pins.byte_n == !byte_mode)
        else $error("bus width pin wrong");
    a_done_ready: assert property ($rose(req_ready) |-> rsp_valid)
        else $error("ready without response");
    a_ready_resp: assert property (rsp_valid |-> req_ready)
        else $error("response without ready");
endmodule // fci_host_props
bind fci_host fci_host_props #(.WP_CYCLES(WP_CYCLES)) u_props (.ref_clk(ref_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .byte_mode(byte_mode),
    .prog_enable(prog_enable), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .pins(pins),
    .program_enable_supply_drive(program_enable_supply_drive));

// file: fci_flash_model.sv
`timescale 1ns/1ns
module fci_flash_model #(
    parameter int         BUSY_CYC    = 20,
    parameter logic [7:0] MAKER_CODE  = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h3c  // Arbitrary value
) (
    input  wire logic               ref_clk,
    input  wire fci_pkg::fci_pins_s pins,
    input  wire logic               program_enable_supply,
    output logic [15:0]             dq_in,
    output logic [15:0]             last_data,
    output logic [15:0]             rcfg,
    output logic [7:0]              locks,
    output int                      e8_cnt,
    output int                      bad_cmd,
    output int                      buf_seen,
    output int                      busy_cnt
);
    logic [2:0]  ph, nx;
    logic [1:0]  mode;
    logic [7:0]  d;
    logic [5:0]  left;
    logic [22:0] k;
    logic [15:0] rd;
    logic        susp, start;
    wire         run = busy_cnt > 0 && !susp;
    initial begin
        {ph, susp, start, locks, e8_cnt, bad_cmd, buf_seen, busy_cnt} = '0;
        mode = 2'h0;
        rcfg = 16'h0000; // Asynchronous page mode
    end
    function automatic logic [7:0] qbyte(input logic [22:0] a);
        case (a)
            23'h10: return 8'h51;
            23'h11: return 8'h52;
            23'h12: return 8'h59;
            23'h13: return 8'h01;
            23'h15: return 8'h31;
            default: return 8'h00;
        endcase
    endfunction
    task automatic go;
        if (program_enable_supply)
            start = 1'b1;
        mode = 2'h3;
    endtask
    always @(posedge ref_clk)
        if (start) begin
            busy_cnt = BUSY_CYC;
            start = 1'b0;
        end else if (run)
            busy_cnt = busy_cnt - 1;
    always @(posedge pins.we_n) if (!pins.ce_n) begin
        d = pins.dq_out[7:0];
        nx = 3'h0;
        case (ph)
            3'h0: case (d)
                8'hff: if (!run) mode = 2'h0;
                8'h90: mode = 2'h1;
                8'h98: mode = 2'h2;
                8'h70: mode = 2'h3;
                8'h50: ;
                8'he8: begin // Not free while the engine runs
                    e8_cnt++;
                    mode = 2'h3;
                    nx = run ? 3'h0 : 3'h2;
                end
                8'h40, 8'h10, 8'hc0: nx = 3'h1;
                8'h20: nx = 3'h5;
                8'hb0: susp = 1'b1;
                8'hd0: susp = 1'b0;
                8'hb8: nx = 3'h7;
                8'h60: nx = 3'h6;
                default: bad_cmd++;
            endcase
            3'h1: begin
                last_data = pins.dq_out;
                go();
            end
            3'h2: begin
                left = pins.dq_out[5:0] + 6'h01;
                nx = 3'h3;
            end
            3'h3: begin
                last_data = pins.dq_out;
                buf_seen++;
                left--;
                nx = left == 0 ? 3'h4 : 3'h3;
            end
            3'h4, 3'h5: if (d == 8'hd0) go();
            3'h6: if (d == 8'h03)
                rcfg = pins.addr[16:1];
            else begin
                if (d == 8'hd0)
                    locks = 8'h00;
                else
                    locks[pins.addr[3:1]] = 1'b1;
                go();
            end
            default: ;
        endcase
        ph = nx;
    end
    always @* begin
        k = pins.addr[23:1];
        case (mode)
            2'h1: rd = {8'h00, k == 0 ? MAKER_CODE : k == 1 ? DEVICE_CODE : locks};
            2'h2: rd = {8'h00, qbyte(k)};
            2'h3: rd = run ? 16'hff7f : 16'h0080; // Undriven bits float high while busy; ready status drives them low
            default: rd = last_data;
        endcase
        if (!pins.byte_n)
            rd[15:8] = 8'hff;
    end
    // Pull-up holds released lines high
    assign dq_in = (pins.ce_n || pins.oe_n) ? 16'hffff : rd;
endmodule // fci_flash_model

// file: fci_host_test.sv
`timescale 1ns/1ns
module fci_host_test;
    typedef struct packed {
        fci_pkg::fci_op_e op;
        logic [7:0]       a;
        logic [15:0]      d;
        logic [2:0]       fl;
        logic [15:0]      x;
    } fci_row_s;
    localparam fci_row_s ROWS [20] = '{
        '{fci_pkg::OP_READ_ID, 8'h00, 16'h0000, 3'h5, 16'h005a},
        '{fci_pkg::OP_READ_ID, 8'h01, 16'h0000, 3'h5, 16'h003c},
        '{fci_pkg::OP_QUERY, 8'h10, 16'h0000, 3'h5, 16'h5251},
        '{fci_pkg::OP_QUERY, 8'h12, 16'h0000, 3'h5, 16'h0159},
        '{fci_pkg::OP_QUERY, 8'h13, 16'h0000, 3'h5, 16'h0001},
        '{fci_pkg::OP_STATUS, 8'h00, 16'h0000, 3'h5, 16'h0080},
        '{fci_pkg::OP_BUFFER, 8'h00, 16'h0010, 3'h6, 16'h0000},
        '{fci_pkg::OP_PROGRAM, 8'h05, 16'h1234, 3'h2, 16'h0000},
        '{fci_pkg::OP_PROGRAM, 8'h05, 16'h1234, 3'h4, 16'h0000},
        '{fci_pkg::OP_STATUS, 8'h00, 16'h0000, 3'h5, 16'h0000},
        '{fci_pkg::OP_SUSPEND, 8'h00, 16'h0000, 3'h4, 16'h0000},
        '{fci_pkg::OP_READ_ARRAY, 8'h00, 16'h0000, 3'h4, 16'h0000},
        '{fci_pkg::OP_RESUME, 8'h00, 16'h0000, 3'h4, 16'h0000},
        '{fci_pkg::OP_ERASE, 8'h08, 16'h0000, 3'h4, 16'h0000},
        '{fci_pkg::OP_LOCK_SET, 8'h02, 16'h0000, 3'h4, 16'h0000},
        '{fci_pkg::OP_LOCK_CLEAR, 8'h00, 16'h0000, 3'h4, 16'h0000},
        '{fci_pkg::OP_CLR_STATUS, 8'h00, 16'h0000, 3'h4, 16'h0000},
        '{fci_pkg::OP_CONFIG, 8'h00, 16'h0000, 3'h4, 16'h0000},
        '{fci_pkg::OP_PROTECT, 8'h03, 16'hbeef, 3'h4, 16'h0000},
        '{fci_pkg::OP_READ_ARRAY, 8'h00, 16'h0000, 3'h0, 16'h0000}
    };
    logic ref_clk, rst_n, req_valid, req_ready, byte_mode, prog_enable, buf_valid, buf_ready;
    logic rsp_valid, rsp_err, program_enable_supply_drive;
    logic [15:0] buf_data, rsp_data, dq_in, last_data, rcfg;
    logic [7:0] locks;
    fci_pkg::fci_req_s req;
    fci_pkg::fci_pins_s pins;
    int e8_cnt, bad_cmd, buf_seen, busy_cnt, feed, b0, e0;
    int fails = 0;
    int total_checks = 0;
    fci_host #(.WP_CYCLES(2), .WPH_CYCLES(1), .RD_CYCLES(3)) DUT (.ref_clk(ref_clk),
        .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .byte_mode(byte_mode), .prog_enable(prog_enable), .buf_valid(buf_valid),
        .buf_data(buf_data), .buf_ready(buf_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
        .rsp_data(rsp_data), .pins(pins), .program_enable_supply_drive(program_enable_supply_drive), .dq_in(dq_in));
    fci_flash_model mdl (.ref_clk(ref_clk), .pins(pins), .program_enable_supply(program_enable_supply_drive), .dq_in(dq_in),
        .last_data(last_data), .rcfg(rcfg), .locks(locks), .e8_cnt(e8_cnt),
        .bad_cmd(bad_cmd), .buf_seen(buf_seen), .busy_cnt(busy_cnt));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic req_do(input fci_pkg::fci_op_e op, input logic [23:0] a,
        input logic [15:0] dt, input logic [2:0] fl, input logic [15:0] x);
        @(negedge ref_clk);
        prog_enable = fl[2];
        req_valid = 1'b1;
        req = '{op, a, dt};
        do @(posedge ref_clk); while (req_ready !== 1'b1);
        @(negedge ref_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge ref_clk);
        check({15'h0000, rsp_err}, {15'h0000, fl[1]});
        if (fl[0])
            check(rsp_data, x);
    endtask
    task automatic print_verdict;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk) if (buf_valid && buf_ready) feed <= feed + 1;
    always @(negedge ref_clk) buf_data <= 16'ha000 + 16'(feed);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
    initial begin
        {rst_n, req_valid, req, byte_mode, feed} = '0;
        {prog_enable, buf_valid} = 2'h3;
        repeat (8) @(negedge ref_clk);
        check({13'h0000, req_ready, pins.ce_n, pins.dq_oe}, 16'h0006);
        rst_n = 1'b1;
        foreach (ROWS[i])
            req_do(ROWS[i].op, {16'h0000, ROWS[i].a}, ROWS[i].d, ROWS[i].fl, ROWS[i].x);
        check(last_data, 16'hbeef);
        check({8'h00, locks}, 16'h0000);
        while (busy_cnt > 0) @(negedge ref_clk);
        b0 = buf_seen;
        req_do(fci_pkg::OP_BUFFER, 24'h000040, 16'h0003, 3'h4, 16'h0000);
        check(16'(buf_seen - b0), 16'h0004);
        check(16'(busy_cnt > 0), 16'h0001);
        e0 = e8_cnt;
        req_do(fci_pkg::OP_BUFFER, 24'h000040, 16'h0000, 3'h4, 16'h0000);
        check(16'(e8_cnt - e0 > 1), 16'h0001);
        while (busy_cnt > 0) @(negedge ref_clk);
        req_do(fci_pkg::OP_RCFG, 24'h000000, 16'h5a5a, 3'h4, 16'h0000);
        check(rcfg, 16'h5a5a);
        byte_mode = 1'b1;
        req_do(fci_pkg::OP_QUERY, 24'h000010, 16'h0000, 3'h5, 16'h5251);
        req_do(fci_pkg::OP_BUFFER, 24'h000000, 16'h0020, 3'h6, 16'h0000);
        byte_mode = 1'b0;
        rst_n = 1'b0;
        @(negedge ref_clk);
        check({13'h0000, req_ready, pins.ce_n, pins.we_n}, 16'h0007);
        rst_n = 1'b1;
        req_do(fci_pkg::OP_READ_ID, 24'h000001, 16'h0000, 3'h1, 16'h003c);
        check(16'(bad_cmd), 16'h0000);
        print_verdict();
    end
endmodule // fci_host_test
